// file: design/dcf_defs.svh
// Constants for the dual clock FIFO: geometry, reset values, register map.
// Assumes inclusion by bare name from the package and the FIFO module.
`ifndef DCF_DEFS_SVH
`define DCF_DEFS_SVH

// Geometry of the smallest depth variant
`define DCF_WIDTH           18
`define DCF_DEPTH           256
`define DCF_AW              8
`define DCF_CW              9
`define DCF_TW              10
`define DCF_DEPTH_C         9'h100
`define DCF_DEPTH_T         10'h100
`define DCF_DEPTH_P1_T      10'h101
`define DCF_HALF_T          10'h080
`define DCF_HALF_P1_T       10'h081

// Fall-through load happens on the third read clock rising edge
`define DCF_FALL_LAST       2'h2

// Offset reset values (31 words for the 256 deep variant)
`define DCF_EMPTY_OFF_RST   8'h1F
`define DCF_FULL_OFF_RST    8'h1F

// APB register byte addresses
`define DCF_ADDR_EMPTY_OFF  8'h00
`define DCF_ADDR_FULL_OFF   8'h04
`define DCF_ADDR_STATUS     8'h08

// Status register field positions
`define DCF_ST_COUNT_LSB    0
`define DCF_ST_OV_BIT       9
`define DCF_ST_FALL_BIT     10
`define DCF_ST_FLAG_LSB     11

`endif

// file: design/dcf_pkg.sv
// Types and reset state for the dual clock FIFO.
// Assumes dcf_defs.svh is reachable on the include path.
`include "dcf_defs.svh"

package dcf_pkg;

    // Whole state of the FIFO block
    typedef struct packed {
        logic [2:0]                                 wclk_p;
        logic [2:0]                                 rclk_p;
        logic [1:0]                                 wen_p;
        logic [1:0]                                 ren_p;
        logic [1:0]                                 devrst_p;
        logic [1:0]                                 ld_p;
        logic [1:0]                                 rdx_p;
        logic [1:0]                                 wrx_p;
        logic [`DCF_WIDTH-1:0]                      din_1;
        logic [`DCF_WIDTH-1:0]                      din_2;
        logic                                       fall_mode;
        logic [7:0]                                 empty_off;
        logic [7:0]                                 full_off;
        logic [`DCF_DEPTH-1:0][`DCF_WIDTH-1:0]      mem;
        logic [`DCF_AW-1:0]                         wr_ptr;
        logic [`DCF_AW-1:0]                         rd_ptr;
        logic [`DCF_CW-1:0]                         count;
        logic                                       ov;
        logic [1:0]                                 fall_cnt;
        logic [`DCF_WIDTH-1:0]                      dout;
        logic                                       empty_n;
        logic                                       out_rdy_n;
        logic                                       full_n;
        logic                                       in_rdy_n;
        logic                                       ae_n;
        logic                                       af_n;
        logic                                       half_n;
        logic                                       pready;
        logic                                       pslverr;
        logic [31:0]                                prdata;
    } dcf_state_t;

    // Constant state of an empty FIFO in standard mode
    function automatic dcf_state_t dcf_reset_state();
        dcf_state_t s;
        s           = '0;
        s.empty_off = `DCF_EMPTY_OFF_RST;
        s.full_off  = `DCF_FULL_OFF_RST;
        s.out_rdy_n = 1'b1;
        s.full_n    = 1'b1;
        s.in_rdy_n  = 1'b1;
        s.af_n      = 1'b1;
        s.half_n    = 1'b1;
        return s;
    endfunction : dcf_reset_state

endpackage : dcf_pkg

// file: design/dcf_fifo.sv
// 18 bit FIFO with standard and fall-through timing, APB offset registers.
// Assumes pin inputs are slow against ref_clk: each clock phase of the
// write and read clocks spans at least two ref_clk periods.
//
// How it works
// R1: timing mode sampled from pins during reset
// R2: standard mode shows data only after read
// R3: fall-through loads first word on third edge
// R4: write captured each write edge while enabled
// R5: standard empty flag rises after first write
// R6: standard almost-empty high above n words
// R7: almost-empty default offset is 31 words
// R8: standard half-full low above 128 words
// R9: standard almost-full low at 256-m words
// R10: standard full at 256 words, writes blocked
// R11: reads from full release full, then others
// R12: standard empty low at zero, reads ignored
// R13: output ready low while output word valid
// R14: fall-through almost-empty high above n+1 words
// R15: fall-through half-full low above 129 words
// R16: fall-through almost-full low at 257-m words
// R17: input ready high at 257 words, writes blocked
// R18: read from full drops input ready
// R19: output ready high when last word read
// R20: refused write or read changes nothing
// R21: one count updated by both ports together
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "dcf_defs.svh"

module dcf_fifo
    import dcf_pkg::*;
(
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    input  wire logic                   device_reset_n,
    input  wire logic                   initial_load_sel,
    input  wire logic                   rd_expansion_in,
    input  wire logic                   wr_expansion_in,
    input  wire logic                   write_clock,
    input  wire logic                   write_enable_n,
    input  wire logic [`DCF_WIDTH-1:0]  data_in,
    input  wire logic                   read_clock,
    input  wire logic                   read_enable_n,
    output logic      [`DCF_WIDTH-1:0]  data_out,
    output logic                        empty_ind_n,
    output logic                        output_ready_n,
    output logic                        full_ind_n,
    output logic                        input_ready_n,
    output logic                        almost_empty_ind_n,
    output logic                        almost_full_ind_n,
    output logic                        half_full_ind_n,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr
);

    // Unsigned at-least comparison on word counts
    function automatic logic dcf_ge(input logic [`DCF_TW-1:0] a, input logic [`DCF_TW-1:0] b);
        return a >= b;
    endfunction : dcf_ge

    dcf_state_t st;
    dcf_state_t next_st;

    logic                   wr_edge;
    logic                   rd_edge;
    logic                   dev_rst;
    logic                   do_wr;
    logic                   do_rd;
    logic                   pop_out;
    logic                   mem_has;
    logic [`DCF_TW-1:0]     cnt_t;
    logic [`DCF_TW-1:0]     tot_t;
    logic [`DCF_TW-1:0]     n_t;
    logic [`DCF_TW-1:0]     m_t;
    logic [31:0]            rd_val;
    logic                   addr_ok;

    // Next state of every flip-flop
    always_comb begin
        next_st = st;

        // Two flip-flop pin synchronisers, third stage for edge detection
        next_st.wclk_p   = {st.wclk_p[1:0], write_clock};
        next_st.rclk_p   = {st.rclk_p[1:0], read_clock};
        next_st.wen_p    = {st.wen_p[0], write_enable_n};
        next_st.ren_p    = {st.ren_p[0], read_enable_n};
        next_st.devrst_p = {st.devrst_p[0], device_reset_n};
        next_st.ld_p     = {st.ld_p[0], initial_load_sel};
        next_st.rdx_p    = {st.rdx_p[0], rd_expansion_in};
        next_st.wrx_p    = {st.wrx_p[0], wr_expansion_in};
        next_st.din_1    = data_in;
        next_st.din_2    = st.din_1;

        wr_edge = st.wclk_p[1] & ~st.wclk_p[2];
        rd_edge = st.rclk_p[1] & ~st.rclk_p[2];
        dev_rst = ~st.devrst_p[1];
        mem_has = (st.count != '0);
        do_wr   = 1'b0;
        do_rd   = 1'b0;
        pop_out = 1'b0;

        if (dev_rst) begin
            // R1: mode follows pins while device reset held
            next_st.fall_mode = st.ld_p[1] & ~st.rdx_p[1] & ~st.wrx_p[1];
            next_st.wr_ptr   = '0;
            next_st.rd_ptr   = '0;
            next_st.count    = '0;
            next_st.ov       = 1'b0;
            next_st.fall_cnt = '0;
            next_st.dout     = '0;
        end else begin
            // R4: capture on write edge
            // R10: full memory refuses writes
            // R17: same memory limit in fall-through
            do_wr = wr_edge & ~st.wen_p[1] & (st.count != `DCF_DEPTH_C);
            if (st.fall_mode) begin
                // R19: pop only a valid output word
                pop_out = rd_edge & ~st.ren_p[1] & st.ov;
                // R3: load on third edge without enable
                do_rd = mem_has & ((~st.ov & rd_edge & (st.fall_cnt == `DCF_FALL_LAST)) | pop_out);
            end else begin
                // R2: word moves out only on a read
                // R12: reads ignored while empty
                do_rd = rd_edge & ~st.ren_p[1] & mem_has;
            end

            // R20: refused accesses touch no storage
            if (do_wr) begin
                next_st.mem[st.wr_ptr] = st.din_2;
                next_st.wr_ptr         = st.wr_ptr + 1'b1;
            end
            if (do_rd) begin
                next_st.dout   = st.mem[st.rd_ptr];
                next_st.rd_ptr = st.rd_ptr + 1'b1;
            end

            // R21: single count for both ports
            next_st.count = st.count + `DCF_CW'(do_wr) - `DCF_CW'(do_rd);

            // Output register occupancy in fall-through mode
            if (st.fall_mode && do_rd) begin
                next_st.ov = 1'b1;
            end else if (pop_out) begin
                next_st.ov = 1'b0;
            end

            // Edges counted while a word waits for the empty output
            if (st.fall_mode && !st.ov && mem_has && rd_edge && !do_rd) begin
                next_st.fall_cnt = st.fall_cnt + 1'b1;
            end else if (st.ov || !mem_has || do_rd) begin
                next_st.fall_cnt = '0;
            end
        end

        // Flags from the settled count of the next cycle
        cnt_t = `DCF_TW'(next_st.count);
        tot_t = cnt_t + `DCF_TW'(next_st.ov);
        n_t   = `DCF_TW'(st.empty_off);
        m_t   = `DCF_TW'(st.full_off);
        if (next_st.fall_mode) begin
            next_st.empty_n   = 1'b1;
            next_st.full_n    = 1'b1;
            // R13: low while output word valid
            next_st.out_rdy_n = ~next_st.ov;
            // R18: drops as soon as a word leaves
            next_st.in_rdy_n  = (tot_t == `DCF_DEPTH_P1_T);
            // R14: high from n+2 words
            next_st.ae_n      = dcf_ge(tot_t, n_t + `DCF_TW'(2));
            // R15: low from 130 words
            next_st.half_n    = ~dcf_ge(tot_t, `DCF_HALF_P1_T + `DCF_TW'(1));
            // R16: low from 257-m words
            next_st.af_n      = ~dcf_ge(tot_t, `DCF_DEPTH_P1_T - m_t);
        end else begin
            next_st.out_rdy_n = 1'b1;
            next_st.in_rdy_n  = 1'b1;
            // R5: high once a word is stored
            next_st.empty_n   = (cnt_t != '0);
            // R11: rises on the first read from full
            next_st.full_n    = (cnt_t != `DCF_DEPTH_T);
            // R6: high from n+1 words
            // R7: n starts at 31 after reset
            next_st.ae_n      = dcf_ge(cnt_t, n_t + `DCF_TW'(1));
            // R8: low from 129 words
            next_st.half_n    = ~dcf_ge(cnt_t, `DCF_HALF_P1_T);
            // R9: low from 256-m words
            next_st.af_n      = ~dcf_ge(cnt_t, `DCF_DEPTH_T - m_t);
        end

        // APB read mux and address check
        addr_ok = 1'b1;
        rd_val  = '0;
        unique case (paddr)
            `DCF_ADDR_EMPTY_OFF: rd_val[7:0] = st.empty_off;
            `DCF_ADDR_FULL_OFF:  rd_val[7:0] = st.full_off;
            `DCF_ADDR_STATUS: begin
                rd_val[`DCF_ST_COUNT_LSB +: `DCF_CW] = st.count;
                rd_val[`DCF_ST_OV_BIT]               = st.ov;
                rd_val[`DCF_ST_FALL_BIT]             = st.fall_mode;
                rd_val[`DCF_ST_FLAG_LSB +: 7]        = {st.half_n, st.af_n, st.ae_n, st.in_rdy_n,
                                                        st.full_n, st.out_rdy_n, st.empty_n};
            end
            default: addr_ok = 1'b0;
        endcase

        // APB slave: answer one cycle into the access phase
        if (psel && penable && !st.pready) begin
            next_st.pready  = 1'b1;
            next_st.pslverr = ~addr_ok;
            next_st.prdata  = pwrite ? 32'h0000_0000 : rd_val;
        end else if (psel && penable && st.pready) begin
            next_st.pready  = 1'b0;
            next_st.pslverr = 1'b0;
            if (pwrite && paddr == `DCF_ADDR_EMPTY_OFF) begin
                next_st.empty_off = pwdata[7:0];
            end
            if (pwrite && paddr == `DCF_ADDR_FULL_OFF) begin
                next_st.full_off = pwdata[7:0];
            end
        end else begin
            next_st.pready  = 1'b0;
            next_st.pslverr = 1'b0;
        end
    end

    // State register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st <= dcf_reset_state();
        end else begin
            st <= next_st;
        end
    end

    // Outputs taken straight from the state register
    assign data_out           = st.dout;
    assign empty_ind_n        = st.empty_n;
    assign output_ready_n     = st.out_rdy_n;
    assign full_ind_n         = st.full_n;
    assign input_ready_n      = st.in_rdy_n;
    assign almost_empty_ind_n = st.ae_n;
    assign almost_full_ind_n  = st.af_n;
    assign half_full_ind_n    = st.half_n;
    assign prdata             = st.prdata;
    assign pready             = st.pready;
    assign pslverr            = st.pslverr;

endmodule : dcf_fifo

// file: bench/dcf_peer.sv
// Producer and consumer model for the FIFO write and read ports.
// Assumes ref_clk paces it; port clocks stand low between words.
`timescale 1ns/1ps
module dcf_peer (
    input  wire logic        ref_clk,
    output logic             write_clock,
    output logic             write_enable_n,
    output logic [17:0]      data_in,
    output logic             read_clock,
    output logic             read_enable_n
);
    logic [17:0] wdat;
    // Idle levels
    initial begin
        write_clock = 1'b0;
        write_enable_n = 1'b1;
        data_in = 18'h3FFFF;
        read_clock = 1'b0;
        read_enable_n = 1'b1;
        wdat = 18'h000A5;
    end
    task automatic push(input int k);
        repeat (k) begin
            @(posedge ref_clk);
            write_enable_n <= 1'b0;
            data_in <= wdat;
            repeat (3) @(posedge ref_clk);
            write_clock <= 1'b1;
            repeat (3) @(posedge ref_clk);
            write_clock <= 1'b0;
            wdat <= wdat + 18'h1;
        end
        write_enable_n <= 1'b1;
        data_in <= ~data_in; // Released bus shows inverse
    endtask : push
    task automatic pop(input int k, input logic en);
        repeat (k) begin
            @(posedge ref_clk);
            read_enable_n <= ~en;
            repeat (3) @(posedge ref_clk);
            read_clock <= 1'b1;
            repeat (3) @(posedge ref_clk);
            read_clock <= 1'b0;
        end
        read_enable_n <= 1'b1;
    endtask : pop
endmodule : dcf_peer

// file: bench/dcf_fifo_checker.sv
// Flag table and APB answer checks for the FIFO, one ref_clk domain.
// Assumes bind into dcf_fifo with default offsets n = m = 31.
`timescale 1ns/1ps
module dcf_fifo_checker (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        device_reset_n,
    input wire logic [17:0] data_out,
    input wire logic        empty_ind_n,
    input wire logic        output_ready_n,
    input wire logic        full_ind_n,
    input wire logic        input_ready_n,
    input wire logic        almost_empty_ind_n,
    input wire logic        almost_full_ind_n,
    input wire logic        half_full_ind_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready
);
    logic [2:0] run;
    // Cycles since the device reset pin went high
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) run <= 3'h0;
        else if (!device_reset_n) run <= 3'h0;
        else if (run != 3'h7) run <= run + 3'h1;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst || run < 3'h6);
    property p_full_row; !full_ind_n |-> !almost_full_ind_n && !half_full_ind_n && almost_empty_ind_n; endproperty
    a_full_row: assert property (p_full_row) else $error("full row wrong");
    property p_empty_row; !empty_ind_n |-> !almost_empty_ind_n && half_full_ind_n && almost_full_ind_n; endproperty
    a_empty_row: assert property (p_empty_row) else $error("empty row wrong");
    property p_inrdy_row; input_ready_n && !output_ready_n |-> !almost_full_ind_n && !half_full_ind_n; endproperty
    a_inrdy_row: assert property (p_inrdy_row) else $error("input ready row wrong");
    property p_or_row; !input_ready_n && output_ready_n |-> !almost_empty_ind_n && half_full_ind_n; endproperty
    a_or_row: assert property (p_or_row) else $error("output ready row wrong");
    property p_hold; !empty_ind_n && $past(!empty_ind_n) |-> $stable(data_out); endproperty
    a_hold: assert property (p_hold) else $error("data moved while empty");
    property p_full_rise; $rose(full_ind_n) |-> !almost_full_ind_n; endproperty
    a_full_rise: assert property (p_full_rise) else $error("full release wrong");
    property p_inrdy_fall; $fell(input_ready_n) && !output_ready_n |-> !almost_full_ind_n; endproperty
    a_inrdy_fall: assert property (p_inrdy_fall) else $error("input ready release wrong");
    property p_apb; psel && penable && !pready |=> pready ##1 !pready; endproperty
    a_apb: assert property (p_apb) else $error("apb answer timing wrong");
    cover property ($fell(full_ind_n));
    cover property ($rose(input_ready_n) && !output_ready_n);
    cover property ($fell(output_ready_n));
endmodule : dcf_fifo_checker

bind dcf_fifo dcf_fifo_checker chk (.ref_clk, .rst, .device_reset_n, .data_out, .empty_ind_n,
    .output_ready_n, .full_ind_n, .input_ready_n, .almost_empty_ind_n, .almost_full_ind_n,
    .half_full_ind_n, .psel, .penable, .pready);

// file: bench/test_dual_clock_fifo_timing_modes.sv
// Bench for the FIFO: mode straps, APB registers, both timing modes.
// Assumes dcf_peer drives the ports and the checker is bound in.
`timescale 1ns/1ps
module test_dual_clock_fifo_timing_modes;
    logic        ref_clk = 1'b0, rst = 1'b1, device_reset_n = 1'b0;
    logic        initial_load_sel = 1'b0, rd_expansion_in = 1'b0, wr_expansion_in = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        write_clock, write_enable_n, read_clock, read_enable_n, empty_ind_n, output_ready_n;
    logic        full_ind_n, input_ready_n, almost_empty_ind_n, almost_full_ind_n, half_full_ind_n;
    logic [17:0] data_in, data_out, exp_w;
    int          fail_count = 0, num_checks = 0, cyc = 0;
    wire  [6:0]  flags = {input_ready_n, output_ready_n, full_ind_n, almost_full_ind_n,
                          half_full_ind_n, almost_empty_ind_n, empty_ind_n};
    dcf_fifo dut (.ref_clk, .rst, .device_reset_n, .initial_load_sel, .rd_expansion_in, .wr_expansion_in,
        .write_clock, .write_enable_n, .data_in, .read_clock, .read_enable_n, .data_out, .empty_ind_n,
        .output_ready_n, .full_ind_n, .input_ready_n, .almost_empty_ind_n, .almost_full_ind_n,
        .half_full_ind_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    dcf_peer peer (.ref_clk, .write_clock, .write_enable_n, .data_in, .read_clock, .read_enable_n);
    // Clock of 100 ns period
    initial forever #50 ref_clk = ~ref_clk;
    // Hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    // Compare and count
    task automatic chk(input logic [31:0] seen, exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic settle();
        repeat (6) @(posedge ref_clk);
    endtask : settle
    // Device reset with straps
    task automatic dev_reset(input logic [2:0] s);
        device_reset_n <= 1'b0;
        {initial_load_sel, rd_expansion_in, wr_expansion_in} <= s;
        repeat (5) @(posedge ref_clk);
        device_reset_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        exp_w = peer.wdat;
    endtask : dev_reset
    // One APB transfer, answer judged
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, ed, input logic ee);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // Wait for the answer; only the hang guard ends a lost one
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        if (!w) chk(prdata, ed, "prdata");
        chk({31'h0, pslverr}, {31'h0, ee}, "pslverr");
    endtask : apb
    // Write in steps, flags after each
    task automatic fill(input int n[10], input logic [6:0] f[10]);
        for (int i = 0; i < 10; i++) begin
            peer.push(n[i]);
            settle();
            chk(32'(flags), 32'(f[i]), "flags");
        end
    endtask : fill
    // Read out 256 words in order, then read while empty
    task automatic tail(input logic [6:0] f);
        for (int i = 0; i < 256; i++) begin
            chk(32'(data_out), 32'(exp_w), "data");
            exp_w++;
            peer.pop(1, 1'b1);
            settle();
        end
        chk(32'(flags), 32'(f), "flags");
        peer.pop(1, 1'b1);
        settle();
        chk(32'(data_out), 32'(exp_w - 18'h1), "idle");
    endtask : tail
    task automatic rd1(input logic [6:0] f);
        peer.pop(1, 1'b1);
        settle();
        chk(32'(flags), 32'(f), "flags");
    endtask : rd1
    // Standard mode, two words, then writes and reads on the same edges
    task automatic mix();
        logic [17:0] w0;
        w0 = peer.wdat;
        peer.push(2);
        fork
            peer.push(2);
            peer.pop(2, 1'b1);
        join
        settle();
        chk(32'(flags), 32'h7D, "mix flags");
        chk(32'(data_out), 32'(w0 + 18'h1), "mix data");
    endtask : mix
    // Closing report
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // Main sequence
    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        for (int s = 0; s < 8; s++) begin
            dev_reset(3'(s));
            chk(32'(flags), (s == 4) ? 32'h3D : 32'h7C, "mode");
        end
        apb(1'b0, 8'h00, 32'h0, 32'h1F, 1'b0);
        apb(1'b0, 8'h04, 32'h0, 32'h1F, 1'b0);
        apb(1'b1, 8'h00, 32'h15, 32'h0, 1'b0);
        apb(1'b0, 8'h00, 32'h0, 32'h15, 1'b0);
        apb(1'b1, 8'h00, 32'h1F, 32'h0, 1'b0);
        apb(1'b1, 8'h04, 32'h2A, 32'h0, 1'b0);
        apb(1'b0, 8'h04, 32'h0, 32'h2A, 1'b0);
        apb(1'b1, 8'h04, 32'h1F, 32'h0, 1'b0);
        apb(1'b1, 8'h08, 32'hFFFF, 32'h0, 1'b0);
        apb(1'b0, 8'h08, 32'h0, 32'h37000, 1'b0);
        apb(1'b0, 8'h0C, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 8'h0C, 32'h7, 32'h0, 1'b1);
        fill('{1, 30, 1, 96, 1, 95, 1, 30, 1, 1},
             '{7'h7D, 7'h7D, 7'h7F, 7'h7F, 7'h7B, 7'h7B, 7'h73, 7'h73, 7'h63, 7'h63});
        chk(32'(data_out), 32'h0, "held");
        rd1(7'h73);
        tail(7'h7C);
        mix();
        dev_reset(3'h4);
        peer.push(1);
        settle();
        chk(32'(output_ready_n), 32'h1, "early");
        peer.pop(3, 1'b0);
        settle();
        chk(32'(data_out), 32'(exp_w), "fell");
        fill('{0, 31, 1, 96, 1, 95, 1, 30, 1, 1},
             '{7'h1D, 7'h1D, 7'h1F, 7'h1F, 7'h1B, 7'h1B, 7'h13, 7'h13, 7'h53, 7'h53});
        rd1(7'h13);
        exp_w++;
        tail(7'h3D);
        tally_and_finish();
    end
endmodule : test_dual_clock_fifo_timing_modes
